// ===== blrlc_array_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Array side model: answers requests promptly or slowly
// ==========================================================================
module blrlc_array_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic req,
  input  wire logic abort,
  input  wire logic slow,
  input  wire logic set_corr,
  input  wire logic set_fail,
  output logic      done,
  output logic      ecc_corr,
  output logic      ecc_fail
);
  logic       busy_reg;
  logic       done_reg;
  logic       tog_reg;
  logic [5:0] cnt_reg;

  // Busy counter, aborted operation never completes
  always_ff @(posedge clk)
  begin
    tog_reg  <= rst ? 1'b0 : ~tog_reg;
    done_reg <= 1'b0;
    if (rst || abort)
    begin
      busy_reg <= 1'b0;
      cnt_reg  <= 6'h00;
    end
    else if (req)
    begin
      busy_reg <= 1'b1;
      cnt_reg  <= slow ? 6'h28 : 6'h03;
    end
    else if (busy_reg)
    begin
      if (cnt_reg == 6'h00)
      begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end
      else
        cnt_reg <= cnt_reg - 6'h01;
    end
  end

  // ECC lines only meaningful with done, toggle otherwise
  assign done     = done_reg;
  assign ecc_corr = done_reg ? set_corr : tog_reg;
  assign ecc_fail = done_reg ? set_fail : ~tog_reg;
endmodule : blrlc_array_model

// ===== blrlc_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// (RULE1) Hot reset halts and aborts everything; code ignores it during boot load
// (RULE2) Internal reset reinitialises registers, keeps buffers
// (RULE3) Hot reset aborts array op, buffers kept
// (RULE4) Core reset aborts array op only
// (RULE5) Power-up copies 1KB boot code
// (RULE6) Boot buffer locked after boot load
// (RULE7) All blocks locked after cold/warm reset
// (RULE8) Decode lock and lock-tight command codes
// (RULE9) Protection commands target start block register
// (RULE10) Separate protection state per block
// (RULE11) Status has three flags, survives hot reset
// (RULE12) Status refreshed on block write and command
// (RULE13) Status codes 010 locked, 100, 001
// (RULE14) Unlocked accepts program/erase; lock relocks
// (RULE15) Unlock releases exactly one locked block
// (RULE16) Locked block refuses program and erase
// (RULE17) Locked-tight ignores unlock and lock
// (RULE18) Lock-tight only from locked state
// (RULE19) Load fills buffer, reports ECC results
// (RULE20) Load completion raises host interrupt
// (RULE21) Two page buffers, load one, read other
// (RULE22) Read mode defaults asynchronous after reset
// (RULE23) Warm reset pin stops all, resets
// (RULE24) Unlock command acts on target block
// (RULE25) Protected program/erase rejected, error flagged
module blrlc_ctrl #(
  parameter int NUM_BLOCKS = blrlc_pkg::NUM_BLOCKS,
  parameter int BLK_W      = $clog2(NUM_BLOCKS)
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic             RESET_PIN_N,
  input  wire logic [15:0]      ADDR,
  input  wire logic [15:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [15:0]      RDATA,
  input  wire logic             ARRAY_DONE,
  input  wire logic             ARRAY_ECC_CORR,
  input  wire logic             ARRAY_ECC_FAIL,
  output logic                  ARRAY_REQ,
  output blrlc_pkg::blrlc_op_t  ARRAY_OP,
  output logic      [BLK_W-1:0] ARRAY_BLOCK,
  output logic                  ARRAY_BUF_SEL,
  output logic                  ARRAY_ABORT,
  output logic                  BOOT_LOCKED,
  output logic                  LOAD_INT,
  output logic                  PROT_ERR,
  output logic                  READ_MODE_SYNC
);

  // ========================================================================
  // State and helpers
  // ========================================================================
  blrlc_pkg::blrlc_regs_t r_reg;
  blrlc_pkg::blrlc_regs_t r_next;
  blrlc_pkg::blrlc_lock_t cur_lock;
  blrlc_pkg::blrlc_lock_t mem_wdata;
  logic                   mem_we;
  logic                   cmd_wr;

  assign cmd_wr = WR && (ADDR == blrlc_pkg::ADDR_CMD);

  // Protection transition for one command
  function automatic blrlc_pkg::blrlc_lock_t next_lock(
    input logic [15:0]            c,
    input blrlc_pkg::blrlc_lock_t cur
  );
    next_lock = cur;
    if (cur != blrlc_pkg::BLRLC_TIGHT) // [RULE17]
    begin
      if (c == blrlc_pkg::CMD_LOCK) // [RULE8] [RULE14]
        next_lock = blrlc_pkg::BLRLC_LOCKED;
      else if (c == blrlc_pkg::CMD_UNLOCK && cur == blrlc_pkg::BLRLC_LOCKED)
        next_lock = blrlc_pkg::BLRLC_UNLOCKED; // [RULE15] [RULE24]
      else if (c == blrlc_pkg::CMD_TIGHT && cur == blrlc_pkg::BLRLC_LOCKED)
        next_lock = blrlc_pkg::BLRLC_TIGHT; // [RULE18]
    end
  endfunction : next_lock

  // Three-flag status code of a block
  function automatic logic [15:0] wps_bits(input blrlc_pkg::blrlc_lock_t s);
    unique case (s)
      blrlc_pkg::BLRLC_UNLOCKED: wps_bits = {13'h0000, blrlc_pkg::WPS_UNLOCKED};
      blrlc_pkg::BLRLC_TIGHT:    wps_bits = {13'h0000, blrlc_pkg::WPS_TIGHT};
      default:                   wps_bits = {13'h0000, blrlc_pkg::WPS_LOCKED};
    endcase // [RULE13]
  endfunction : wps_bits

  // True for commands that start an array operation
  function automatic logic is_array_cmd(input logic [15:0] c);
    is_array_cmd = (c == blrlc_pkg::CMD_LOAD) || (c == blrlc_pkg::CMD_PROGRAM) ||
                   (c == blrlc_pkg::CMD_ERASE);
  endfunction : is_array_cmd

  // ========================================================================
  // Protection state store
  // ========================================================================
  // Read address follows the next block number so status is fresh
  blrlc_lock_mem #(
    .DEPTH (NUM_BLOCKS),
    .AW    (BLK_W)
  ) u_lock_mem (
    .clk   (CLK),
    .rst   (RESET),
    .clear (!RESET_PIN_N), // [RULE7] [RULE23]
    .we    (mem_we),
    .waddr (r_reg.blk[BLK_W-1:0]), // [RULE9] [RULE10]
    .wdata (mem_wdata),
    .raddr (r_next.blk[BLK_W-1:0]), // [RULE12]
    .rdata (cur_lock)
  );

  // ========================================================================
  // Register read mux
  // ========================================================================
  function automatic logic [15:0] reg_read(
    input logic [15:0]            a,
    input blrlc_pkg::blrlc_regs_t s,
    input blrlc_pkg::blrlc_lock_t lk
  );
    logic [15:0] st;
    st = 16'h0000;
    st[blrlc_pkg::STAT_BUSY]      = (s.st != blrlc_pkg::ST_IDLE);
    st[blrlc_pkg::STAT_PROT_ERR]  = s.prot_err;
    st[blrlc_pkg::STAT_ECC_CORR]  = s.ecc_corr;
    st[blrlc_pkg::STAT_ECC_FAIL]  = s.ecc_fail;
    st[blrlc_pkg::STAT_LOAD_INT]  = s.load_int;
    st[blrlc_pkg::STAT_BOOT_LOCK] = s.boot_locked;
    unique case (a)
      blrlc_pkg::ADDR_BUF_SEL:  reg_read = {15'h0000, s.buf_sel};
      blrlc_pkg::ADDR_CMD:      reg_read = s.cmd;
      blrlc_pkg::ADDR_CFG:      reg_read = s.cfg;
      blrlc_pkg::ADDR_CTL_STAT: reg_read = st;
      blrlc_pkg::ADDR_BLK:      reg_read = s.blk;
      blrlc_pkg::ADDR_WPS:      reg_read = wps_bits(lk); // [RULE11]
      default:                  reg_read = 16'h0000;
    endcase
  endfunction : reg_read

  // ========================================================================
  // Next-state logic
  // ========================================================================
  always_comb
  begin
    r_next           = r_reg;
    r_next.arr_req   = 1'b0;
    r_next.arr_abort = 1'b0;
    r_next.rdata     = 16'h0000;
    mem_we           = 1'b0;
    mem_wdata        = next_lock(WDATA, cur_lock);
    if (RD)
    begin
      r_next.rdata = reg_read(ADDR, r_reg, cur_lock);
    end
    // Plain register writes
    if (WR && ADDR == blrlc_pkg::ADDR_CFG)
    begin
      r_next.cfg = WDATA; // [RULE22]
    end
    if (WR && ADDR == blrlc_pkg::ADDR_BLK)
    begin
      r_next.blk = WDATA; // [RULE9] [RULE12]
    end
    if (WR && ADDR == blrlc_pkg::ADDR_BUF_SEL)
    begin
      r_next.buf_sel = WDATA[0]; // [RULE21]
    end
    unique case (r_reg.st)
      blrlc_pkg::ST_BOOT:
      begin
        r_next.arr_req = 1'b1; // [RULE5]
        r_next.op      = blrlc_pkg::BLRLC_OP_BOOT;
        r_next.arr_blk = 16'h0000;
        r_next.st      = blrlc_pkg::ST_BOOT_WAIT;
      end
      blrlc_pkg::ST_BOOT_WAIT:
      begin
        if (ARRAY_DONE)
        begin
          r_next.boot_locked = 1'b1; // [RULE6]
          r_next.st          = blrlc_pkg::ST_IDLE;
        end
      end
      blrlc_pkg::ST_IDLE:
      begin
        if (cmd_wr && WDATA == blrlc_pkg::CMD_CORE_RESET)
        begin
          r_next.arr_abort = 1'b1; // [RULE4]
        end
        else if (cmd_wr && WDATA != blrlc_pkg::CMD_HOT_RESET)
        begin
          r_next.cmd      = WDATA;
          r_next.prot_err = 1'b0;
          r_next.load_int = 1'b0;
          r_next.ecc_corr = 1'b0;
          r_next.ecc_fail = 1'b0;
          if (WDATA == blrlc_pkg::CMD_LOCK || WDATA == blrlc_pkg::CMD_TIGHT ||
              WDATA == blrlc_pkg::CMD_UNLOCK)
          begin
            mem_we = 1'b1; // [RULE8] [RULE10] [RULE12] [RULE24]
          end
          else if (is_array_cmd(WDATA))
          begin
            if (WDATA != blrlc_pkg::CMD_LOAD && cur_lock != blrlc_pkg::BLRLC_UNLOCKED)
            begin
              r_next.prot_err = 1'b1; // [RULE16] [RULE25]
            end
            else
            begin
              r_next.arr_req = 1'b1; // [RULE14] [RULE19]
              r_next.arr_blk = r_reg.blk;
              r_next.st      = blrlc_pkg::ST_ARRAY;
              unique case (WDATA)
                blrlc_pkg::CMD_PROGRAM: r_next.op = blrlc_pkg::BLRLC_OP_PROG;
                blrlc_pkg::CMD_ERASE:   r_next.op = blrlc_pkg::BLRLC_OP_ERASE;
                default:                r_next.op = blrlc_pkg::BLRLC_OP_LOAD;
              endcase
            end
          end
        end
      end
      blrlc_pkg::ST_ARRAY:
      begin
        if (cmd_wr && WDATA == blrlc_pkg::CMD_CORE_RESET)
        begin
          r_next.arr_abort = 1'b1; // [RULE4]
          r_next.st        = blrlc_pkg::ST_IDLE;
        end
        else if (ARRAY_DONE)
        begin
          r_next.st = blrlc_pkg::ST_IDLE;
          if (r_reg.op == blrlc_pkg::BLRLC_OP_LOAD)
          begin
            r_next.load_int = 1'b1; // [RULE20]
            r_next.ecc_corr = ARRAY_ECC_CORR; // [RULE19]
            r_next.ecc_fail = ARRAY_ECC_FAIL;
          end
        end
      end
      default:
      begin
        r_next.st = blrlc_pkg::ST_IDLE;
      end
    endcase
    // Hot reset: block number and protection states kept
    if (cmd_wr && WDATA == blrlc_pkg::CMD_HOT_RESET &&
        (r_reg.st == blrlc_pkg::ST_IDLE || r_reg.st == blrlc_pkg::ST_ARRAY))
    begin
      r_next.st        = blrlc_pkg::ST_IDLE; // [RULE1] [RULE3]
      r_next.arr_abort = 1'b1;
      r_next.cmd       = 16'h0000; // [RULE2]
      r_next.cfg       = blrlc_pkg::CFG_RESET;
      r_next.buf_sel   = 1'b0;
      r_next.prot_err  = 1'b0;
      r_next.load_int  = 1'b0;
      r_next.ecc_corr  = 1'b0;
      r_next.ecc_fail  = 1'b0;
      mem_we           = 1'b0; // [RULE11]
    end
    // Warm reset pin: registers back to default except boot lock, which is kept; idle, no boot load
    if (!RESET_PIN_N)
    begin
      r_next             = blrlc_pkg::COLD_INIT; // [RULE23] [RULE22]
      r_next.st          = blrlc_pkg::ST_IDLE;
      r_next.arr_abort   = 1'b1;
      r_next.boot_locked = r_reg.boot_locked;
      mem_we             = 1'b0;
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  always_ff @(posedge CLK)
  begin
    if (RESET)
      r_reg <= blrlc_pkg::COLD_INIT; // [RULE7]
    else
      r_reg <= r_next;
  end

  // Outputs straight from flops
  assign RDATA          = r_reg.rdata;
  assign ARRAY_REQ      = r_reg.arr_req;
  assign ARRAY_OP       = r_reg.op;
  assign ARRAY_BLOCK    = r_reg.arr_blk[BLK_W-1:0];
  assign ARRAY_BUF_SEL  = r_reg.buf_sel; // [RULE21]
  assign ARRAY_ABORT    = r_reg.arr_abort;
  assign BOOT_LOCKED    = r_reg.boot_locked;
  assign LOAD_INT       = r_reg.load_int;
  assign PROT_ERR       = r_reg.prot_err;
  assign READ_MODE_SYNC = r_reg.cfg[blrlc_pkg::CFG_RM_BIT];

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  logic idle_cmd;
  logic run_cmd;
  assign idle_cmd = cmd_wr && RESET_PIN_N && r_reg.st == blrlc_pkg::ST_IDLE;
  // Reset commands are honoured in idle and during an array operation
  assign run_cmd  = cmd_wr && RESET_PIN_N &&
                    (r_reg.st == blrlc_pkg::ST_IDLE || r_reg.st == blrlc_pkg::ST_ARRAY);

  boot_lock_hold_a: assert property (BOOT_LOCKED |=> BOOT_LOCKED) // [RULE6]
    else $error("boot buffer lock dropped");
  hot_abort_a: assert property (run_cmd && WDATA == blrlc_pkg::CMD_HOT_RESET // [RULE1]
    |=> ARRAY_ABORT && !LOAD_INT && r_reg.cmd == 16'h0000)
    else $error("hot reset did not abort and clear");
  hot_keep_blk_a: assert property (run_cmd && WDATA == blrlc_pkg::CMD_HOT_RESET // [RULE11]
    |=> $stable(r_reg.blk) && cur_lock == $past(cur_lock))
    else $error("hot reset changed protection status");
  core_keep_a: assert property (run_cmd && WDATA == blrlc_pkg::CMD_CORE_RESET // [RULE4]
    |=> ARRAY_ABORT && $stable(r_reg.cfg) && $stable(r_reg.cmd))
    else $error("core reset touched registers");
  warm_locked_a: assert property (!RESET_PIN_N // [RULE7]
    |=> cur_lock == blrlc_pkg::BLRLC_LOCKED && !READ_MODE_SYNC && ARRAY_ABORT)
    else $error("warm reset did not lock blocks");
  tight_hold_a: assert property (idle_cmd && cur_lock == blrlc_pkg::BLRLC_TIGHT // [RULE17]
    && WDATA != blrlc_pkg::CMD_HOT_RESET |=> cur_lock == blrlc_pkg::BLRLC_TIGHT)
    else $error("locked-tight block changed");
  tight_only_locked_a: assert property (idle_cmd && WDATA == blrlc_pkg::CMD_TIGHT // [RULE18]
    && cur_lock == blrlc_pkg::BLRLC_UNLOCKED |=> cur_lock == blrlc_pkg::BLRLC_UNLOCKED)
    else $error("lock-tight applied to unlocked block");
  prot_refuse_a: assert property (idle_cmd && WDATA == blrlc_pkg::CMD_ERASE // [RULE16]
    && cur_lock != blrlc_pkg::BLRLC_UNLOCKED |=> PROT_ERR && !ARRAY_REQ)
    else $error("erase of protected block not refused");
  load_int_a: assert property (RESET_PIN_N && r_reg.st == blrlc_pkg::ST_ARRAY // [RULE20]
    && r_reg.op == blrlc_pkg::BLRLC_OP_LOAD && ARRAY_DONE && !cmd_wr |=> LOAD_INT)
    else $error("load completion not signalled");
  unlock_one_a: assert property (idle_cmd && WDATA == blrlc_pkg::CMD_UNLOCK // [RULE15]
    && cur_lock == blrlc_pkg::BLRLC_LOCKED |=> cur_lock == blrlc_pkg::BLRLC_UNLOCKED)
    else $error("unlock did not release block");
  prog_accept_a: assert property (idle_cmd && WDATA == blrlc_pkg::CMD_PROGRAM // [RULE14]
    && cur_lock == blrlc_pkg::BLRLC_UNLOCKED |=> ARRAY_REQ && !PROT_ERR
    && ARRAY_OP == blrlc_pkg::BLRLC_OP_PROG)
    else $error("program of unlocked block not started");

  unlock_c: cover property (idle_cmd && WDATA == blrlc_pkg::CMD_UNLOCK
    ##1 cur_lock == blrlc_pkg::BLRLC_UNLOCKED);
  load_c: cover property (ARRAY_REQ && ARRAY_OP == blrlc_pkg::BLRLC_OP_LOAD ##[1:20] LOAD_INT);
  prot_c: cover property ($rose(PROT_ERR));
  boot_c: cover property ($rose(BOOT_LOCKED));

endmodule : blrlc_ctrl

// ===== blrlc_lock_mem.sv
`timescale 1ns/100ps
// ==========================================================================
// Per-block protection state store
// ==========================================================================
module blrlc_lock_mem #(
  parameter int DEPTH = blrlc_pkg::NUM_BLOCKS,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   clear,
  input  wire logic                   we,
  input  wire logic [AW-1:0]          waddr,
  input  wire blrlc_pkg::blrlc_lock_t wdata,
  input  wire logic [AW-1:0]          raddr,
  output blrlc_pkg::blrlc_lock_t      rdata
);

  typedef struct packed {
    blrlc_pkg::blrlc_lock_t [DEPTH-1:0] cells;
    blrlc_pkg::blrlc_lock_t             rd;
  } blrlc_mem_t;

  blrlc_mem_t r_reg;
  blrlc_mem_t r_next;

  // Clear to locked wins over write; write bypasses to read
  always_comb
  begin
    r_next = r_reg;
    if (clear)
    begin
      r_next = '0;
    end
    else
    begin
      if (we)
      begin
        r_next.cells[waddr] = wdata;
      end
      r_next.rd = (we && waddr == raddr) ? wdata : r_reg.cells[raddr];
    end
  end

  // State register, all cells locked after reset
  always_ff @(posedge clk)
  begin
    if (rst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign rdata = r_reg.rd;

endmodule : blrlc_lock_mem

// ===== blrlc_pkg.sv
// ==========================================================================
// Shared constants and types
// ==========================================================================
package blrlc_pkg;

  // ========================================================================
  // Register offsets
  // ========================================================================
  localparam logic [15:0] ADDR_BUF_SEL   = 16'hF200;
  localparam logic [15:0] ADDR_CMD       = 16'hF220;
  localparam logic [15:0] ADDR_CFG       = 16'hF221;
  localparam logic [15:0] ADDR_CTL_STAT  = 16'hF240;
  localparam logic [15:0] ADDR_BLK       = 16'hF24C;
  localparam logic [15:0] ADDR_WPS       = 16'hF24E;

  // ========================================================================
  // Command codes
  // ========================================================================
  localparam logic [15:0] CMD_LOAD       = 16'h0000;
  localparam logic [15:0] CMD_UNLOCK     = 16'h0023;
  localparam logic [15:0] CMD_LOCK       = 16'h002A;
  localparam logic [15:0] CMD_TIGHT      = 16'h002C;
  localparam logic [15:0] CMD_PROGRAM    = 16'h0080;
  localparam logic [15:0] CMD_ERASE      = 16'h0094;
  localparam logic [15:0] CMD_CORE_RESET = 16'h00F0;
  localparam logic [15:0] CMD_HOT_RESET  = 16'h00F3;

  // ========================================================================
  // Reset values and field positions
  // ========================================================================
  localparam logic [15:0] CFG_RESET      = 16'h40C0;
  localparam int          CFG_RM_BIT     = 15;
  localparam logic [15:0] ZERO16         = 16'h0000;
  localparam logic [2:0]  WPS_UNLOCKED   = 3'h4;
  localparam logic [2:0]  WPS_LOCKED     = 3'h2;
  localparam logic [2:0]  WPS_TIGHT      = 3'h1;
  localparam int          STAT_BUSY      = 0;
  localparam int          STAT_PROT_ERR  = 1;
  localparam int          STAT_ECC_CORR  = 2;
  localparam int          STAT_ECC_FAIL  = 3;
  localparam int          STAT_LOAD_INT  = 4;
  localparam int          STAT_BOOT_LOCK = 5;
  localparam int          NUM_BLOCKS     = 512;
  localparam int          BOOT_BYTES     = 1024;

  // ========================================================================
  // Types
  // ========================================================================
  typedef enum logic [1:0] {
    BLRLC_LOCKED   = 2'h0,
    BLRLC_UNLOCKED = 2'h1,
    BLRLC_TIGHT    = 2'h2
  } blrlc_lock_t;

  typedef enum logic [1:0] {
    BLRLC_OP_BOOT  = 2'h0,
    BLRLC_OP_LOAD  = 2'h1,
    BLRLC_OP_PROG  = 2'h2,
    BLRLC_OP_ERASE = 2'h3
  } blrlc_op_t;

  typedef enum logic [3:0] {
    ST_BOOT      = 4'h1,
    ST_BOOT_WAIT = 4'h2,
    ST_IDLE      = 4'h4,
    ST_ARRAY     = 4'h8
  } blrlc_state_t;

  typedef struct packed {
    blrlc_state_t st;
    logic [15:0]  cmd;
    logic [15:0]  cfg;
    logic [15:0]  blk;
    logic         buf_sel;
    logic [15:0]  rdata;
    logic         arr_req;
    blrlc_op_t    op;
    logic [15:0]  arr_blk;
    logic         arr_abort;
    logic         boot_locked;
    logic         load_int;
    logic         prot_err;
    logic         ecc_corr;
    logic         ecc_fail;
  } blrlc_regs_t;

  localparam blrlc_regs_t COLD_INIT = '{
    st: ST_BOOT, cmd: ZERO16, cfg: CFG_RESET, blk: ZERO16, buf_sel: 1'b0,
    rdata: ZERO16, arr_req: 1'b0, op: BLRLC_OP_BOOT, arr_blk: ZERO16,
    arr_abort: 1'b0, boot_locked: 1'b0, load_int: 1'b0, prot_err: 1'b0,
    ecc_corr: 1'b0, ecc_fail: 1'b0};

endpackage : blrlc_pkg

// ===== testbench.sv
`timescale 1ns/100ps
// ==========================================================================
// Self-checking bench
// ==========================================================================
module testbench;
  logic        CLK = 1'b0, RESET = 1'b1, RESET_PIN_N = 1'b1, WR = 1'b0, RD = 1'b0;
  logic [15:0] ADDR = 16'h0000, WDATA = 16'h0000, RDATA;
  logic        done, corr, fail, req, abort, buf_sel, boot_lk, load_int, prot_err, rm;
  logic        slow = 1'b0, s_corr = 1'b0, s_fail = 1'b0, rd_d = 1'b0;
  logic [1:0]  op;
  logic [8:0]  blk, b, b2;
  logic [15:0] seed = 16'h0010, exp_q[$], msk_q[$];
  int          n_fail = 0, checked = 0, n_req = 0, n_abort = 0, old;

  blrlc_ctrl dut_u (.CLK(CLK), .RESET(RESET), .RESET_PIN_N(RESET_PIN_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ARRAY_DONE(done),
    .ARRAY_ECC_CORR(corr), .ARRAY_ECC_FAIL(fail), .ARRAY_REQ(req), .ARRAY_OP(op),
    .ARRAY_BLOCK(blk), .ARRAY_BUF_SEL(buf_sel), .ARRAY_ABORT(abort),
    .BOOT_LOCKED(boot_lk), .LOAD_INT(load_int), .PROT_ERR(prot_err),
    .READ_MODE_SYNC(rm));
  blrlc_array_model arr_u (.clk(CLK), .rst(RESET), .req(req), .abort(abort), .slow(slow),
    .set_corr(s_corr), .set_fail(s_fail), .done(done), .ecc_corr(corr), .ecc_fail(fail));

  // Clock, 50 ns period
  always #25 CLK = ~CLK;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // Bus cycles, entered just after a rising edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    WR <= 1'b1; RD <= 1'b0; ADDR <= a; WDATA <= d;
    @(posedge CLK);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    RD <= 1'b1; WR <= 1'b0; ADDR <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge CLK);
  endtask : rd

  task automatic idle(input int n);
    WR <= 1'b0; RD <= 1'b0;
    repeat (n) @(posedge CLK);
  endtask : idle

  // Bounded wait: 0 request, 1 boot lock, 2 done
  task automatic wait_for(input int sel);
    int i;
    idle(0);
    for (i = 0; i < 200; i++)
    begin
      @(negedge CLK);
      if ((sel == 0 && req === 1'b1) || (sel == 1 && boot_lk === 1'b1) ||
          (sel == 2 && done === 1'b1))
        break;
    end
    @(posedge CLK);
    if (i == 200)
    begin
      n_fail++;
      test_done();
    end
  endtask : wait_for

  // Read data monitor, oldest note first
  always @(posedge CLK) rd_d <= RD;
  always @(negedge CLK)
  begin
    if (req === 1'b1) n_req++;
    if (abort === 1'b1) n_abort++;
    if (rd_d)
      chk(RDATA & msk_q.pop_front(), exp_q.pop_front());
  end

  initial
  begin
    seed = lfsr_next(seed);
    b    = seed[8:0] | 9'h002;
    b2   = b ^ 9'h001;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    wait_for(0);
    chk({14'h0, op}, {14'h0, blrlc_pkg::BLRLC_OP_BOOT});
    chk({7'h0, blk}, 16'h0000);
    rd(blrlc_pkg::ADDR_WPS, 16'h0002, 16'hFFFF);
    rd(blrlc_pkg::ADDR_CFG, 16'h40C0, 16'hFFFF);
    wait_for(1);
    chk(16'(rm), 16'h0000);
    wr(blrlc_pkg::ADDR_BLK, {7'h0, b});
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_UNLOCK);
    rd(blrlc_pkg::ADDR_WPS, 16'h0004, 16'hFFFF);
    wr(blrlc_pkg::ADDR_BLK, {7'h0, b2});
    rd(blrlc_pkg::ADDR_WPS, 16'h0002, 16'hFFFF);
    wr(blrlc_pkg::ADDR_BLK, {7'h0, b});
    rd(blrlc_pkg::ADDR_WPS, 16'h0004, 16'hFFFF);
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_TIGHT);
    rd(blrlc_pkg::ADDR_WPS, 16'h0004, 16'hFFFF);
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_PROGRAM);
    wait_for(0);
    chk({14'h0, op}, {14'h0, blrlc_pkg::BLRLC_OP_PROG});
    chk({7'h0, blk}, {7'h0, b});
    wait_for(2);
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_LOCK);
    rd(blrlc_pkg::ADDR_WPS, 16'h0002, 16'hFFFF);
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_TIGHT);
    rd(blrlc_pkg::ADDR_WPS, 16'h0001, 16'hFFFF);
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_UNLOCK);
    rd(blrlc_pkg::ADDR_WPS, 16'h0001, 16'hFFFF);
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_LOCK);
    rd(blrlc_pkg::ADDR_WPS, 16'h0001, 16'hFFFF);
    old = n_req;
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_ERASE);
    idle(3);
    chk(16'(prot_err), 16'h0001);
    chk(16'(n_req - old), 16'h0000);
    // Load into buffer one with random ECC outcome
    seed   = lfsr_next(seed);
    s_corr <= seed[6];
    s_fail <= seed[6];
    wr(blrlc_pkg::ADDR_BUF_SEL, 16'h0001);
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_LOAD);
    wait_for(0);
    chk({14'h0, op}, {14'h0, blrlc_pkg::BLRLC_OP_LOAD});
    chk(16'(buf_sel), 16'h0001);
    wait_for(2);
    idle(1);
    chk(16'(load_int), 16'h0001);
    rd(blrlc_pkg::ADDR_CTL_STAT, {11'h0, 1'b1, seed[6], seed[6], 2'h0}, 16'h001D);
    wr(blrlc_pkg::ADDR_CFG, 16'hC0C0);
    idle(2);
    chk(16'(rm), 16'h0001);
    // Hot reset in the middle of a slow load
    slow <= 1'b1;
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_LOAD);
    wait_for(0);
    old = n_abort;
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_HOT_RESET);
    idle(3);
    chk(16'(n_abort > old), 16'h0001);
    rd(blrlc_pkg::ADDR_CFG, 16'h40C0, 16'hFFFF);
    rd(blrlc_pkg::ADDR_WPS, 16'h0001, 16'hFFFF);
    wr(blrlc_pkg::ADDR_CFG, 16'hC0C0);
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_LOAD);
    wait_for(0);
    old = n_abort;
    wr(blrlc_pkg::ADDR_CMD, blrlc_pkg::CMD_CORE_RESET);
    idle(3);
    chk(16'(n_abort > old), 16'h0001);
    rd(blrlc_pkg::ADDR_CFG, 16'hC0C0, 16'hFFFF);
    rd(blrlc_pkg::ADDR_BLK, {7'h0, b}, 16'hFFFF);
    idle(2);
    // Warm reset through the pin
    old = n_abort;
    RESET_PIN_N <= 1'b0;
    idle(4);
    RESET_PIN_N <= 1'b1;
    idle(2);
    chk(16'(n_abort > old), 16'h0001);
    chk(16'(boot_lk), 16'h0001);
    rd(blrlc_pkg::ADDR_CFG, 16'h40C0, 16'hFFFF);
    wr(blrlc_pkg::ADDR_BLK, {7'h0, b});
    rd(blrlc_pkg::ADDR_WPS, 16'h0002, 16'hFFFF);
    rd(16'h1234, 16'h0000, 16'hFFFF);
    idle(3);
    test_done();
  end
endmodule : testbench
